// File: dsp_pkg.sv
package dsp_pkg;

    // Local clock and the stable-clock wait before the clock gate may rise
    localparam int CLK_MHZ = 100;
    localparam int STABLE_US = 200;
    localparam int STABLE_CYC = STABLE_US * CLK_MHZ;
    localparam int PWR_CNT_W = 15;

    // Read latency in link clock cycles, and the latency counter load value
    localparam int READ_LAT = 3;
    localparam logic [1:0] RD_LAT_LOAD = 2'(READ_LAT - 1);

    // Address geometry
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int BANKS = 4;
    localparam int MEM_AW = 8;
    localparam int AP_BIT = 10;

    // Mode register fields
    localparam int MODE_W = 12;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [MODE_W-1:0] MODE_RST = 12'h031;
    localparam int EMR_DLL_BIT = 0;
    localparam int EMR_SEL_BIT = 0;

    // APB register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_REFCNT = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_RD = 0;
    localparam int ST_WR = 1;
    localparam int ST_OPEN_LSB = 2;
    localparam int ST_EARLY = 6;
    localparam int ST_DLL = 7;
    localparam int REFCNT_W = 16;

    // Command code as {row strobe, column strobe, write strobe}
    typedef enum logic [2:0] {
        CMD_MODE = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR = 3'b100,
        CMD_RD = 3'b101,
        CMD_STOP = 3'b110,
        CMD_NOP = 3'b111
    } dsp_cmd_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LAT = 2'b01,
        RD_BURST = 2'b11
    } dsp_rd_state_t;

endpackage

// File: dsp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second
module dsp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Both stages advance together so every bit sees the same delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // dsp_sync

// File: dsp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Commands on clock rise; data on strobe edges
// - Clock gate low freezes the memory clock
// - Decoder accepts commands only with select low
// - Select high ignores commands; bursts continue
// - Row address captured at row strobe low
// - Column address captured at column strobe low
// - Write strobe picks write or precharge
// - Each byte strobe qualifies its own byte
// - High mask blocks its byte, no latency
// - Mask affects writes only, never reads
// - Data lines driven only during reads
// - Bank select picks one of four banks
// - Twelve row bits, nine column bits
// - Burst 2/4/8, sequential or interleaved
// - First read data three cycles after command
// - Reads edge-aligned, writes centred on strobes
// - Mode fields: length, order, latency (latency field is only stored; read latency is fixed at three)
module dsp_top #(
    parameter int STABLE_CYC_P = dsp_pkg::STABLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mem_ck,
    input wire logic clock_gate_in,
    input wire logic select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [dsp_pkg::ROW_W-1:0] addr_lines,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    input wire logic [15:0] data_lines_in,
    output logic [15:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic low_byte_strobe_in,
    output logic low_byte_strobe_out,
    output logic low_byte_strobe_oe,
    input wire logic high_byte_strobe_in,
    output logic high_byte_strobe_out,
    output logic high_byte_strobe_oe
);
    import dsp_pkg::*;

    logic [39:0] pin_raw;
    logic [39:0] pin_s;
    logic ck_s, cke_s, cs_n_s;
    logic [2:0] cmd_s;
    logic [1:0] ba_s;
    logic [ROW_W-1:0] addr_s;
    logic [1:0] mask_s;
    logic [15:0] dq_s;
    logic [1:0] dqs_s;
    logic ck_d_r, cke_d_r;
    logic [1:0] dqs_d_r;
    logic ck_rise, ck_edge, cmd_valid;
    dsp_cmd_t cmd;
    logic ctrl_en_r;
    logic [BANKS-1:0] open_r;
    logic [ROW_W-1:0] row_r [BANKS];
    logic [MODE_W-1:0] mode_r;
    logic dll_en_r;
    logic [REFCNT_W-1:0] refcnt_r;
    logic [PWR_CNT_W-1:0] pwr_cnt_r;
    logic early_r;
    logic [2:0] blm;
    logic ilv;
    dsp_rd_state_t rd_st_r;
    logic [1:0] rd_lat_r;
    logic [2:0] rd_beat_r;
    logic [2:0] rd_sel;
    logic [1:0] rd_bank_r;
    logic [COL_W-1:0] rd_col_r;
    logic [COL_W-1:0] rd_col;
    logic [MEM_AW-1:0] rd_idx;
    logic [7:0] rd_byte [2];
    logic rd_go, wr_go;
    logic [1:0] wr_bank_r;
    logic [COL_W-1:0] wr_col_r;
    logic [1:0] wr_act;
    logic wr_busy;
    logic [15:0] dq_out_r;
    logic dq_oe_r;
    logic dqs_out_r;
    logic dqs_oe_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic sel_setup, wr_acc;
    logic [31:0] rd_mux;
    logic mapped;

    // Column of a given beat: the low bits wrap inside the burst block
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
                                                   input logic [2:0] beat,
                                                   input logic [2:0] m,
                                                   input logic il);
        logic [2:0] off;
        off = il ? (base[2:0] ^ beat) : 3'(base[2:0] + beat);
        return {base[COL_W-1:3], (base[2:0] & ~m) | (off & m)};
    endfunction

    // Every pin crosses into pclk through the same two stages, so a command
    // and its address stay aligned with the detected clock edge
    assign pin_raw = {mem_ck, clock_gate_in, select_n, row_strobe_n, column_strobe_n,
                      write_strobe_n, bank_select, addr_lines, high_byte_mask,
                      low_byte_mask, data_lines_in, high_byte_strobe_in, low_byte_strobe_in};

    dsp_sync #(.W(40)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .d(pin_raw),
        .q(pin_s)
    );

    assign ck_s = pin_s[39];
    assign cke_s = pin_s[38];
    assign cs_n_s = pin_s[37];
    assign cmd_s = pin_s[36:34];
    assign ba_s = pin_s[33:32];
    assign addr_s = pin_s[31:20];
    assign mask_s = pin_s[19:18];
    assign dq_s = pin_s[17:2];
    assign dqs_s = pin_s[1:0];

    // Previous samples for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_d_r <= 1'b0;
            cke_d_r <= 1'b0;
            dqs_d_r <= 2'b00;
        end else if (ce) begin
            ck_d_r <= ck_s;
            cke_d_r <= cke_s;
            dqs_d_r <= dqs_s;
        end
    end

    // Internal clock runs only while the gate is high
    assign ck_rise = cke_s & ck_s & ~ck_d_r;
    assign ck_edge = cke_s & (ck_s ^ ck_d_r);
    // Decoder disabled while select is high or software has turned it off
    assign cmd_valid = ck_rise & ~cs_n_s & ctrl_en_r;
    assign cmd = dsp_cmd_t'(cmd_s);

    // Burst length mask and ordering from the mode register
    always_comb begin
        unique case (mode_r[MODE_BL_LSB +: 3])
            BL_CODE_4: blm = 3'b011;
            BL_CODE_8: blm = 3'b111;
            default: blm = 3'b001;
        endcase
    end
    assign ilv = mode_r[MODE_BT_BIT];

    // Bank rows: activate opens, precharge closes one or all banks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_r <= '0;
            for (int b = 0; b < BANKS; b++) begin
                row_r[b] <= '0;
            end
        end else if (ce && cmd_valid) begin
            unique case (cmd)
                CMD_ACT: begin
                    open_r[ba_s] <= 1'b1;
                    row_r[ba_s] <= addr_s;
                end
                CMD_PRE: begin
                    if (addr_s[AP_BIT]) begin
                        open_r <= '0;
                    end else begin
                        open_r[ba_s] <= 1'b0;
                    end
                end
                CMD_MODE, CMD_REF, CMD_WR, CMD_RD, CMD_STOP, CMD_NOP: begin
                end
            endcase
        end
    end

    // Mode and extended mode writes; bank bit 0 tells them apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RST;
            dll_en_r <= 1'b0;
        end else if (ce && cmd_valid && cmd == CMD_MODE) begin
            if (ba_s[EMR_SEL_BIT]) begin
                dll_en_r <= addr_s[EMR_DLL_BIT];
            end else begin
                mode_r <= addr_s;
            end
        end
    end

    // Refresh counter; a refresh in the clearing cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refcnt_r <= '0;
        end else if (ce) begin
            if (cmd_valid && cmd == CMD_REF) begin
                refcnt_r <= REFCNT_W'(refcnt_r + 1'b1);
            end else if (wr_acc && paddr == REG_REFCNT) begin
                refcnt_r <= '0;
            end
        end
    end

    // Flags a clock gate raised before the stable-clock wait has elapsed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_cnt_r <= '0;
            early_r <= 1'b0;
        end else if (ce) begin
            if (!cke_s && 32'(pwr_cnt_r) < STABLE_CYC_P) begin
                pwr_cnt_r <= PWR_CNT_W'(pwr_cnt_r + 1'b1);
            end
            if (cke_s && !cke_d_r && 32'(pwr_cnt_r) < STABLE_CYC_P) begin
                early_r <= 1'b1;
            end
        end
    end

    // A read is not taken while a write burst is still running
    assign rd_go = cmd_valid && cmd == CMD_RD && rd_st_r == RD_IDLE && !wr_busy;
    assign wr_go = cmd_valid && cmd == CMD_WR && rd_st_r == RD_IDLE;
    assign wr_busy = |wr_act;

    // Beat about to be launched and its memory word
    assign rd_sel = (rd_st_r == RD_BURST) ? 3'(rd_beat_r + 1'b1) : 3'b000;
    assign rd_col = burst_col(rd_col_r, rd_sel, blm, ilv);
    assign rd_idx = {rd_bank_r, row_r[rd_bank_r][1:0], rd_col[3:0]};

    // Read burst: wait out the latency on clock rises, then one beat per
    // clock edge with the strobe toggling alongside the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_st_r <= RD_IDLE;
            rd_lat_r <= '0;
            rd_beat_r <= '0;
            rd_bank_r <= '0;
            rd_col_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= 1'b0;
            dqs_out_r <= 1'b0;
            dqs_oe_r <= 1'b0;
        end else if (ce) begin
            unique case (rd_st_r)
                RD_IDLE: begin
                    if (rd_go) begin
                        rd_st_r <= RD_LAT;
                        rd_lat_r <= RD_LAT_LOAD;
                        rd_bank_r <= ba_s;
                        rd_col_r <= addr_s[COL_W-1:0];
                    end
                end
                RD_LAT: begin
                    if (ck_rise) begin
                        if (rd_lat_r == 2'b00) begin
                            rd_st_r <= RD_BURST;
                            rd_beat_r <= 3'b000;
                            dq_out_r <= {rd_byte[1], rd_byte[0]};
                            dq_oe_r <= 1'b1;
                            dqs_out_r <= 1'b1;
                            dqs_oe_r <= 1'b1;
                        end else begin
                            rd_lat_r <= 2'(rd_lat_r - 1'b1);
                        end
                    end
                end
                RD_BURST: begin
                    if (ck_edge) begin
                        if (rd_beat_r == blm) begin
                            rd_st_r <= RD_IDLE;
                            dq_oe_r <= 1'b0;
                            dqs_oe_r <= 1'b0;
                            dqs_out_r <= 1'b0;
                        end else begin
                            rd_beat_r <= 3'(rd_beat_r + 1'b1);
                            dq_out_r <= {rd_byte[1], rd_byte[0]};
                            dqs_out_r <= ~dqs_out_r;
                        end
                    end
                end
                default: begin
                    rd_st_r <= RD_IDLE;
                    dq_oe_r <= 1'b0;
                    dqs_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Write burst start address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_bank_r <= '0;
            wr_col_r <= '0;
        end else if (ce && wr_go) begin
            wr_bank_r <= ba_s;
            wr_col_r <= addr_s[COL_W-1:0];
        end
    end

    // One lane per byte: its own strobe, mask and storage
    for (genvar i = 0; i < 2; i++) begin : g_lane
        logic [7:0] mem_r [2**MEM_AW];
        logic act_r;
        logic [2:0] cnt_r;
        logic stb_edge;
        logic [COL_W-1:0] wcol;
        logic [MEM_AW-1:0] widx;

        assign stb_edge = dqs_s[i] ^ dqs_d_r[i];
        assign wcol = burst_col(wr_col_r, cnt_r, blm, ilv);
        assign widx = {wr_bank_r, row_r[wr_bank_r][1:0], wcol[3:0]};
        assign wr_act[i] = act_r;
        assign rd_byte[i] = mem_r[rd_idx];

        // Beat counter; a new write command wins over the last beat
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                act_r <= 1'b0;
                cnt_r <= '0;
            end else if (ce) begin
                if (wr_go) begin
                    act_r <= 1'b1;
                    cnt_r <= 3'b000;
                end else if (act_r && stb_edge) begin
                    if (cnt_r == blm) begin
                        act_r <= 1'b0;
                    end
                    cnt_r <= 3'(cnt_r + 1'b1);
                end
            end
        end

        // Storage has no reset; mask applies to the beat it arrives with
        always_ff @(posedge pclk) begin
            if (ce && act_r && stb_edge && !mask_s[i]) begin
                mem_r[widx] <= dq_s[8*i +: 8];
            end
        end
    end

    // APB slave with no wait states: answer in the first access cycle
    assign sel_setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_r & pwrite;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                    (paddr == REG_MODE) || (paddr == REG_REFCNT);

    // Read data multiplexer
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            REG_CTRL: rd_mux[CTRL_EN_BIT] = ctrl_en_r;
            REG_STATUS: begin
                rd_mux[ST_RD] = (rd_st_r != RD_IDLE);
                rd_mux[ST_WR] = wr_busy;
                rd_mux[ST_OPEN_LSB +: BANKS] = open_r;
                rd_mux[ST_EARLY] = early_r;
                rd_mux[ST_DLL] = dll_en_r;
            end
            REG_MODE: rd_mux[MODE_W-1:0] = mode_r;
            REG_REFCNT: rd_mux[REFCNT_W-1:0] = refcnt_r;
            default: rd_mux = '0;
        endcase
    end

    // Answer registers; data is captured in setup and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else if (ce) begin
            pready_r <= sel_setup;
            if (sel_setup) begin
                pslverr_r <= ~mapped;
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Control register: turning the decoder off ignores new commands only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= CTRL_EN_RST;
        end else if (ce && wr_acc && paddr == REG_CTRL) begin
            ctrl_en_r <= pwdata[CTRL_EN_BIT];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign data_lines_out = dq_out_r;
    assign data_lines_oe = dq_oe_r;
    assign low_byte_strobe_out = dqs_out_r;
    assign high_byte_strobe_out = dqs_out_r;
    assign low_byte_strobe_oe = dqs_oe_r;
    assign high_byte_strobe_oe = dqs_oe_r;
endmodule // dsp_top

// File: dsp_top_assertions.sv
`timescale 1ns/1ps
// Pin and register bus checks
module dsp_checker (
    input wire logic pclk, presetn, ce, psel, penable, pready, pslverr, mem_ck,
    input wire logic clock_gate_in, select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    input wire logic data_lines_oe, low_byte_strobe_out, low_byte_strobe_oe,
    input wire logic high_byte_strobe_out, high_byte_strobe_oe,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [15:0] data_lines_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] ck_r;
    logic [3:0] rd_cnt_r;
    // Rises found one stage ahead of the block, so the count always leads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_r <= 2'h0;
        end else begin
            ck_r <= {ck_r[0], mem_ck};
        end
    end
    // Link clock rises since the last read taken; 15 means none seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt_r <= 4'hf;
        end else if (ck_r[0] && !ck_r[1]) begin
            if (clock_gate_in && !select_n && row_strobe_n && !column_strobe_n && write_strobe_n) begin
                rd_cnt_r <= 4'h0;
            end else if (rd_cnt_r != 4'hf) begin
                rd_cnt_r <= rd_cnt_r + 4'h1;
            end
        end
    end
    rd_latency_a: assert property ($rose(data_lines_oe) |-> rd_cnt_r == 4'h3)
        else $error("read latency not three");
    drive_window_a: assert property (data_lines_oe |-> rd_cnt_r >= 4'h3 && rd_cnt_r <= 4'h7)
        else $error("data lines driven outside a read burst");
    strobe_drive_a: assert property (data_lines_oe |-> low_byte_strobe_oe && high_byte_strobe_oe)
        else $error("strobes not driven with read data");
    lane_match_a: assert property (low_byte_strobe_out == high_byte_strobe_out)
        else $error("byte strobes differ");
    first_beat_a: assert property ($rose(data_lines_oe) |-> low_byte_strobe_out)
        else $error("strobe not high with first beat");
    edge_align_a: assert property (data_lines_oe && $past(data_lines_oe) && $changed(data_lines_out)
        |-> $changed(low_byte_strobe_out))
        else $error("read data moved without a strobe edge");
    apb_answer_a: assert property (ce && psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready && $past(psel) && $past(penable))
        else $error("ready not a one-cycle access pulse");
    unmapped_word_a: assert property (psel && !penable && paddr > 8'h0c |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule // dsp_checker

bind dsp_top dsp_checker dsp_checker_i (.*);

// File: dsp_ctrl_model.sv
`timescale 1ns/1ps
// Controller stand-in: free-running link clock, commands, write strobes
module dsp_ctrl_model (
    input wire logic pclk,
    input wire logic [15:0] dq_bus,
    output logic mem_ck, clock_gate_in, select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    output logic low_byte_mask, high_byte_mask, lo_stb, hi_stb,
    output logic [1:0] bank_select,
    output logic [11:0] addr_lines,
    output logic [15:0] dq_drv
);
    // Link clock runs free, phase unrelated to pclk; the gate hides it
    initial begin
        mem_ck = 1'b0;
        #3;
        forever #80 mem_ck = ~mem_ck;
    end
    // Power-up: gate low, the rest arbitrary
    initial begin
        clock_gate_in = 1'b0;
        select_n = 1'b1;
        {row_strobe_n, column_strobe_n, write_strobe_n} = 3'b111;
        {low_byte_mask, high_byte_mask, lo_stb, hi_stb, bank_select, addr_lines} = '0;
        dq_drv = 16'h5aa5;
    end
    // One command held a whole link period around its rise, then no-op
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                         input logic sel_n);
        @(negedge mem_ck);
        @(posedge pclk);
        {row_strobe_n, column_strobe_n, write_strobe_n} <= c;
        select_n <= sel_n;
        bank_select <= b;
        addr_lines <= a;
        @(negedge mem_ck);
        @(posedge pclk);
        {row_strobe_n, column_strobe_n, write_strobe_n} <= 3'b111;
        select_n <= 1'b0;
    endtask
    task automatic gate(input logic g);
        @(negedge mem_ck);
        @(posedge pclk);
        clock_gate_in <= g;
    endtask
    // Data changes 40 ns before each strobe edge so edges sit mid-beat
    task automatic write_burst(input logic [11:0] col, input int bl, input logic [127:0] d,
                               input logic [7:0] mlo, input logic [7:0] mhi);
        issue(3'b100, 2'h1, col, 1'b0);
        for (int i = 0; i < bl; i++) begin
            dq_drv <= d[16*i +: 16];
            low_byte_mask <= mlo[i];
            high_byte_mask <= mhi[i];
            repeat (4) @(posedge pclk);
            lo_stb <= ~lo_stb;
            hi_stb <= ~hi_stb;
            repeat (4) @(posedge pclk);
        end
        // Released lines show the inverse of the last beat
        dq_drv <= ~dq_drv;
        low_byte_mask <= 1'b0;
        high_byte_mask <= 1'b0;
    endtask
    // Masks held high; a deselected precharge may land mid-latency
    task automatic read_burst(input logic [11:0] col, input int bl, input logic intf,
                              output logic [127:0] q);
        q = '0;
        low_byte_mask <= 1'b1;
        high_byte_mask <= 1'b1;
        issue(3'b101, 2'h1, col, 1'b0);
        if (intf) begin
            issue(3'b010, 2'h0, 12'h400, 1'b1);
            @(posedge mem_ck);
        end else begin
            repeat (3) @(posedge mem_ck);
        end
        #50;
        for (int i = 0; i < bl; i++) begin
            q[16*i +: 16] = dq_bus;
            #80;
        end
        @(posedge pclk);
        low_byte_mask <= 1'b0;
        high_byte_mask <= 1'b0;
    endtask
endmodule // dsp_ctrl_model

// File: dsp_top_bench.sv
`timescale 1ns/1ps
// APB tasks and the controller stand-in drive the block
module dsp_top_bench;
    import dsp_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, data_lines_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] data_lines_out, data_lines_in, dq_drv;
    logic [11:0] addr_lines;
    logic [1:0] bank_select;
    logic mem_ck, clock_gate_in, select_n, row_strobe_n, column_strobe_n, write_strobe_n;
    logic low_byte_mask, high_byte_mask, lo_stb, hi_stb, low_byte_strobe_in, high_byte_strobe_in;
    logic low_byte_strobe_out, low_byte_strobe_oe, high_byte_strobe_out, high_byte_strobe_oe;
    logic [127:0] q, pat;
    logic [15:0] mem_exp [8];
    logic [31:0] rmask [5] = '{32'h1, 32'hfc, 32'hfff, 32'hffff, 32'hffffffff};
    logic [31:0] rexp [5] = '{32'h1, 32'h80, 32'h31, 32'h2, 32'h0};
    int error_cnt = 0, comparisons = 0, bl, c;
    // Shared lines resolved from the block's output enables alone
    assign data_lines_in = data_lines_oe ? data_lines_out : dq_drv;
    assign low_byte_strobe_in = low_byte_strobe_oe ? low_byte_strobe_out : lo_stb;
    assign high_byte_strobe_in = high_byte_strobe_oe ? high_byte_strobe_out : hi_stb;
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    dsp_top #(.STABLE_CYC_P(16)) dsp_top_i (.*);
    dsp_ctrl_model dsp_ctrl_model_i (.*, .dq_bus(data_lines_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One transfer; a clock edge always passes before psel rises again
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic serr);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic open_banks(input logic [31:0] exp);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        check(rd & 32'h3c, exp);
    endtask
    // Burst-8 write at column 0; keeps the expected image
    task automatic wr8(input logic [127:0] d, input logic [7:0] mlo, input logic [7:0] mhi);
        dsp_ctrl_model_i.write_burst(12'h000, 8, d, mlo, mhi);
        for (int i = 0; i < 8; i++) begin
            if (!mlo[i]) mem_exp[i][7:0] = d[16*i +: 8];
            if (!mhi[i]) mem_exp[i][15:8] = d[16*i+8 +: 8];
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard: the sequence needs about 15 us
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Gate low past the shortened stable-clock wait
        repeat (30) @(posedge pclk);
        dsp_ctrl_model_i.issue(3'b111, 2'h0, 12'h000, 1'b0);
        dsp_ctrl_model_i.gate(1'b1);
        dsp_ctrl_model_i.issue(3'b010, 2'h0, 12'h400, 1'b0);
        dsp_ctrl_model_i.issue(3'b000, 2'h1, 12'h001, 1'b0);
        repeat (2) dsp_ctrl_model_i.issue(3'b001, 2'h0, 12'h000, 1'b0);
        dsp_ctrl_model_i.issue(3'b000, 2'h0, 12'h031, 1'b0);
        // Register values after setup (DLL bit set), refresh count, an unmapped word last
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, err);
            check(rd & rmask[i], rexp[i]);
            check({31'h0, err}, 32'(i == 4));
        end
        apb(1'b1, REG_REFCNT, 32'h0, rd, err);
        apb(1'b0, REG_REFCNT, 32'h0, rd, err);
        check(rd, 32'h0);
        // Only the first activate may open a row
        dsp_ctrl_model_i.issue(3'b011, 2'h1, 12'h005, 1'b0);
        dsp_ctrl_model_i.gate(1'b0);
        dsp_ctrl_model_i.issue(3'b011, 2'h2, 12'h005, 1'b0);
        dsp_ctrl_model_i.gate(1'b1);
        dsp_ctrl_model_i.issue(3'b011, 2'h3, 12'h005, 1'b1);
        open_banks(32'h8);
        dsp_ctrl_model_i.issue(3'b000, 2'h0, 12'h033, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) begin
                pat[16*i +: 16] = {8'(160 + 32 * k + i), 8'(80 + i - 48 * k)};
            end
            wr8(pat, k ? 8'h04 : 8'h00, k ? 8'h20 : 8'h00);
        end
        // Every burst length in both orders, from column 5
        for (int m = 0; m < 6; m++) begin
            bl = 2 << (m / 2);
            dsp_ctrl_model_i.issue(3'b000, 2'h0, 12'(49 + m / 2 + 8 * (m % 2)), 1'b0);
            dsp_ctrl_model_i.read_burst(12'h005, bl, m == 3, q);
            for (int i = 0; i < bl; i++) begin
                c = (m % 2) ? (5 ^ i) : ((5 & ~(bl - 1)) | ((5 + i) & (bl - 1)));
                check({16'h0, q[16*i +: 16]}, {16'h0, mem_exp[c]});
            end
            check({31'h0, data_lines_oe}, 32'h0);
        end
        open_banks(32'h8);
        dsp_ctrl_model_i.issue(3'b010, 2'h1, 12'h000, 1'b0);
        open_banks(32'h0);
        give_verdict();
    end
endmodule // dsp_top_bench
